// >>> analog_comparator_control.sv
`timescale 1ns/1ps
`include "analog_comparator_params.svh"

module analog_comparator_control #(
  parameter int ADDR_W = 9
) (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          nrst,
  // register bus
  input  wire analog_comparator_pkg::av_req_t avReq,
  output logic [31:0]                        readdata,
  output logic                               waitrequest,
  // analog core
  input  wire logic                          rawResult,
  output analog_comparator_pkg::analog_ctrl_t anaCtrl,
  input  wire logic                          converterEnable,
  // comparator pins, digital side
  input  wire logic                          positivePinIn,
  input  wire logic                          negativePinIn,
  output logic                               portInPositive,
  output logic                               portInNegative,
  output logic                               resultPinOut,
  output logic                               resultPinOeN,
  // timer capture
  output logic                               captureIn,
  // cpu interrupt
  input  wire logic                          globalIrqEnable,
  input  wire logic                          vectorAck,
  output logic                               comparatorIrq,
  output logic                               irq
);

  analog_comparator_pkg::state_t state_reg;
  analog_comparator_pkg::state_t state_next;

  logic [2:0] syncBits;
  logic       resSync;
  logic       posSync;
  logic       negSync;
  logic       toggle;
  logic       evt;
  logic       req;
  logic       doWrite;
  logic       lane0;
  logic [6:0] idx;
  logic [7:0] wd;
  logic [7:0] rd8;

  if (ADDR_W != 9)
  begin
    $error("analog_comparator_control needs ADDR_W of 9");
  end

  // comparator result and pin levels come from outside the clock domain
  bit_synchronizer #(
    .WIDTH (3)
  ) u_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .asyncIn ({rawResult, positivePinIn, negativePinIn}),
    .syncOut (syncBits)
  );

  assign resSync = syncBits[2];
  assign posSync = syncBits[1];
  assign negSync = syncBits[0];

  assign req     = avReq.read | avReq.write;
  assign doWrite = avReq.write & !state_reg.waitReq;
  assign lane0   = avReq.byteenable[0];
  assign idx     = avReq.address[8:2];
  assign wd      = avReq.writedata[7:0];

  always_comb
  begin
    state_next = state_reg;
    toggle     = resSync ^ state_reg.resPrev;
    evt        = 1'b0;
    rd8        = 8'h00;

    case (state_reg.mode)
      analog_comparator_pkg::MODE_TOGGLE: evt = toggle;
      analog_comparator_pkg::MODE_FALL:   evt = state_reg.resPrev & !resSync;
      analog_comparator_pkg::MODE_RISE:   evt = !state_reg.resPrev & resSync;
      default:                            evt = 1'b0;
    endcase

    state_next.resPrev = resSync;

    // clear by vector, set wins over any clear
    if (vectorAck)
      state_next.flag = 1'b0;

    // bus answer: one wait cycle, then the access completes
    state_next.waitReq = !(req && state_reg.waitReq);

    if (doWrite && lane0)
    begin
      if (idx == `IDX_CTRL_A)
      begin
        state_next.powerOff  = wd[`A_POWER_OFF];
        state_next.posSel    = wd[`A_POS_SEL];
        state_next.irqEnable = wd[`A_IRQ_EN];
        state_next.captureEn = wd[`A_CAPTURE];
        state_next.mode      = analog_comparator_pkg::irq_mode_t'(wd[1:0]);
        if (wd[`A_FLAG])
          state_next.flag = 1'b0;
      end
      else if (idx == `IDX_CTRL_B)
      begin
        state_next.hystEn  = wd[`B_HYST_EN];
        state_next.hystLvl = wd[`B_HYST_LVL];
        state_next.pinEn   = wd[`B_PIN_EN];
        state_next.muxEn   = wd[`B_MUX_EN];
      end
      else if (idx == `IDX_DIDR)
      begin
        state_next.didr = wd;
      end
      else if (idx == `IDX_STATUS)
      begin
        state_next.status = state_reg.status & ~wd[1:0];
      end
      else if (idx == `IDX_MASK)
      begin
        state_next.mask = wd[1:0];
      end
    end

    if (evt)
      state_next.flag = 1'b1;
    if (evt)
      state_next.status[`S_EVENT] = 1'b1;
    if (toggle)
      state_next.status[`S_TOGGLE] = 1'b1;

    // read data prepared so it stands at the completing edge
    if (idx == `IDX_CTRL_A)
    begin
      rd8 = {state_reg.powerOff, state_reg.posSel, resSync, state_reg.flag,
             state_reg.irqEnable, state_reg.captureEn, state_reg.mode};
    end
    else if (idx == `IDX_CTRL_B)
    begin
      rd8 = {state_reg.hystEn, state_reg.hystLvl, 1'b0, state_reg.pinEn,
             1'b0, state_reg.muxEn, 2'b00};
    end
    else if (idx == `IDX_DIDR)
    begin
      rd8 = state_reg.didr;
    end
    else if (idx == `IDX_STATUS)
    begin
      rd8 = {6'h00, state_reg.status};
    end
    else if (idx == `IDX_MASK)
    begin
      rd8 = {6'h00, state_reg.mask};
    end
    else
    begin
      rd8 = 8'h00;
    end
    if (avReq.read && state_reg.waitReq)
      state_next.readData = {24'h000000, rd8};

    // outputs, all registered
    state_next.cmpIrq  = state_reg.flag & state_reg.irqEnable & globalIrqEnable;
    state_next.sysIrq  = |(state_reg.status & state_reg.mask);
    state_next.capture = state_reg.captureEn & resSync;
    state_next.pinOut  = state_reg.pinEn & resSync;
    state_next.pinOeN  = !state_reg.pinEn;
    state_next.portPos = posSync & !state_reg.didr[`D_POS_OFF];
    state_next.portNeg = negSync & !state_reg.didr[`D_NEG_OFF];
    state_next.ana.hystEnable    = state_reg.hystEn;
    state_next.ana.hystLevel     = state_reg.hystEn & state_reg.hystLvl;
    state_next.ana.powerOff      = state_reg.powerOff;
    state_next.ana.posSelBandgap = state_reg.posSel;
    state_next.ana.negMuxSelect  = state_reg.muxEn & !converterEnable;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      state_reg          <= '0;
      state_reg.waitReq  <= 1'b1;
      state_reg.pinOeN   <= 1'b1;
      state_reg.didr     <= `RST_DIDR;
      state_reg.status   <= `RST_STATUS;
      state_reg.mask     <= `RST_MASK;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign readdata       = state_reg.readData;
  assign waitrequest    = state_reg.waitReq;
  assign anaCtrl        = state_reg.ana;
  assign portInPositive = state_reg.portPos;
  assign portInNegative = state_reg.portNeg;
  assign resultPinOut   = state_reg.pinOut;
  assign resultPinOeN   = state_reg.pinOeN;
  assign captureIn      = state_reg.capture;
  assign comparatorIrq  = state_reg.cmpIrq;
  assign irq            = state_reg.sysIrq;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_rise;
    !state_reg.resPrev && resSync;
  endsequence

  sequence s_fall;
    state_reg.resPrev && !resSync;
  endsequence

  sequence s_rise_mode;
    state_reg.mode == analog_comparator_pkg::MODE_RISE;
  endsequence

  a_rise_sets_flag: assert property (s_rise_mode and s_rise |=> state_reg.flag)
    else $error("rising event did not set flag");

  a_fall_sets_flag: assert property (
      (state_reg.mode == analog_comparator_pkg::MODE_FALL) and s_fall |=> state_reg.flag)
    else $error("falling event did not set flag");

  a_toggle_sets_flag: assert property (
      state_reg.mode == analog_comparator_pkg::MODE_TOGGLE && toggle |=> state_reg.flag)
    else $error("toggle event did not set flag");

  a_reserved_no_set: assert property (
      state_reg.mode == analog_comparator_pkg::MODE_RESERVED && !state_reg.flag
      && !(doWrite && lane0 && idx == `IDX_CTRL_A) |=> !state_reg.flag)
    else $error("reserved mode set flag");

  a_event_any_enable: assert property (evt && !state_reg.irqEnable |=> state_reg.flag)
    else $error("event ignored while interrupt disabled");

  a_one_event_edge: assert property (evt |-> toggle)
    else $error("event without change of synchronized result");

  a_irq_gate_ok: assert property (
      comparatorIrq |-> $past(state_reg.flag && state_reg.irqEnable && globalIrqEnable))
    else $error("irq without flag, enable and global enable");

  a_irq_needs_enable: assert property (!state_reg.irqEnable |=> !comparatorIrq)
    else $error("irq raised while enable clear");

  a_vector_clears: assert property (vectorAck && !evt |=> !state_reg.flag)
    else $error("vector did not clear flag");

  a_write_one_clears: assert property (
      doWrite && lane0 && idx == `IDX_CTRL_A && wd[`A_FLAG] && !evt |=> !state_reg.flag)
    else $error("writing one did not clear flag");

  a_write_zero_kept: assert property (
      state_reg.flag && doWrite && lane0 && idx == `IDX_CTRL_A && !wd[`A_FLAG]
      && !vectorAck |=> state_reg.flag)
    else $error("writing zero cleared flag");

  a_result_latency: assert property (
      $rose(rawResult) ##1 rawResult[*2] |-> resSync)
    else $error("result not synchronized in two clocks");

  a_result_read: assert property (
      avReq.read && state_reg.waitReq && idx == `IDX_CTRL_A |=> readdata[`A_RESULT] == $past(resSync))
    else $error("result bit not read back");

  a_capture_route: assert property (
      !state_reg.captureEn |=> !captureIn)
    else $error("capture fed while routing off");

  a_capture_follow: assert property (state_reg.captureEn |=> captureIn == $past(resSync))
    else $error("capture input does not follow result");

  a_ctrl_b_reserved: assert property (
      avReq.read && state_reg.waitReq && idx == `IDX_CTRL_B
      |=> (readdata[5] == 1'b0) && (readdata[3] == 1'b0) && (readdata[1:0] == 2'b00))
    else $error("reserved control b bits not zero");

  a_neg_mux_sel: assert property (
      state_reg.muxEn && converterEnable |=> !anaCtrl.negMuxSelect)
    else $error("mux selected while converter on");

  a_mux_needs_enable: assert property (!state_reg.muxEn |=> !anaCtrl.negMuxSelect)
    else $error("converter mux selected while mux enable clear");

  a_hyst_level_gate: assert property (!state_reg.hystEn |=> !anaCtrl.hystLevel)
    else $error("hysteresis level passed while disabled");

  a_pos_select: assert property (anaCtrl.posSelBandgap == $past(state_reg.posSel))
    else $error("positive input select not passed to core");

  a_neg_pin_off: assert property (state_reg.didr[`D_NEG_OFF] |=> !portInNegative)
    else $error("negative port bit not zero when disabled");

  a_pos_pin_off: assert property (state_reg.didr[`D_POS_OFF] |=> !portInPositive)
    else $error("positive port bit not zero when disabled");

  a_pin_drive: assert property (
      state_reg.pinEn |=> !resultPinOeN && (resultPinOut == $past(resSync)))
    else $error("result pin not driven");

  a_pin_released: assert property (!state_reg.pinEn |=> resultPinOeN && !resultPinOut)
    else $error("result pin driven while disabled");

  a_power_pass: assert property (
      doWrite && lane0 && idx == `IDX_CTRL_A |=> ##1 anaCtrl.powerOff == $past(wd[`A_POWER_OFF], 2))
    else $error("power-off not passed to core");

  a_status_toggle: assert property (toggle |=> state_reg.status[`S_TOGGLE])
    else $error("toggle did not set status");

  a_irq_summary: assert property (irq == $past(|(state_reg.status & state_reg.mask)))
    else $error("summary irq does not follow status and mask");

  a_bus_answer: assert property (req && waitrequest |=> !waitrequest)
    else $error("bus answer late");

endmodule

// >>> analog_comparator_params.svh
`ifndef ANALOG_COMPARATOR_PARAMS_SVH
`define ANALOG_COMPARATOR_PARAMS_SVH

// register indices, byte address is four times the index
`define IDX_CTRL_B    7'h0D
`define IDX_DIDR      7'h60
`define IDX_CTRL_A    7'h0E
`define IDX_STATUS    7'h10
`define IDX_MASK      7'h11

// control register a fields
`define A_POWER_OFF   7
`define A_POS_SEL     6
`define A_RESULT      5
`define A_FLAG        4
`define A_IRQ_EN      3
`define A_CAPTURE     2

// control register b fields
`define B_HYST_EN     7
`define B_HYST_LVL    6
`define B_PIN_EN      4
`define B_MUX_EN      2

// input disable fields
`define D_NEG_OFF     4
`define D_POS_OFF     3

// status and mask fields
`define S_EVENT       0
`define S_TOGGLE      1

// reset values
`define RST_CTRL_A    8'h00
`define RST_CTRL_B    8'h00
`define RST_DIDR      8'h00
`define RST_STATUS    2'h0
`define RST_MASK      2'h0

// synchroniser depth, latency of the result bit in clocks
`define SYNC_STAGES   2

`endif

// >>> analog_comparator_pkg.sv
package analog_comparator_pkg;

  typedef enum logic [1:0] {
    MODE_TOGGLE   = 2'b00,
    MODE_RESERVED = 2'b01,
    MODE_FALL     = 2'b10,
    MODE_RISE     = 2'b11
  } irq_mode_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [8:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } av_req_t;

  typedef struct packed {
    logic        hystEnable;
    logic        hystLevel;
    logic        powerOff;
    logic        posSelBandgap;
    logic        negMuxSelect;
  } analog_ctrl_t;

  typedef struct packed {
    logic        powerOff;
    logic        posSel;
    logic        flag;
    logic        irqEnable;
    logic        captureEn;
    irq_mode_t   mode;
    logic        hystEn;
    logic        hystLvl;
    logic        pinEn;
    logic        muxEn;
    logic [7:0]  didr;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        resPrev;
    logic        waitReq;
    logic [31:0] readData;
    logic        cmpIrq;
    logic        sysIrq;
    logic        capture;
    logic        pinOut;
    logic        pinOeN;
    logic        portPos;
    logic        portNeg;
    analog_ctrl_t ana;
  } state_t;

endpackage

// >>> bit_synchronizer.sv
`timescale 1ns/1ps
`include "analog_comparator_params.svh"

module bit_synchronizer #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  if (WIDTH < 1)
  begin
    $error("bit_synchronizer width must be at least one");
  end

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= asyncIn;
      sync_reg <= meta_reg;
    end
  end

  assign syncOut = sync_reg;

endmodule

// >>> comparator_core_model.sv
`timescale 1ns/1ps
module comparator_core_model #(
  parameter int BANDGAP_MV = 1000
) (
  // settings from the block
  input  analog_comparator_pkg::analog_ctrl_t anaCtrl,
  // analog levels in millivolts
  input  int                                  posPinMv,
  input  int                                  negPinMv,
  input  int                                  muxMv,
  // raw comparator output
  output logic                                rawResult
);
  int posMv;
  int negMv;
  int hyst;

  // hysteresis band centred on the threshold, result held inside it
  always @*
  begin
    posMv = anaCtrl.posSelBandgap ? BANDGAP_MV : posPinMv;
    negMv = anaCtrl.negMuxSelect ? muxMv : negPinMv;
    hyst = anaCtrl.hystEnable ? (anaCtrl.hystLevel ? 50 : 20) : 0;
    if (anaCtrl.powerOff)
      rawResult = 1'b0;
    else if (posMv > negMv + hyst / 2)
      rawResult = 1'b1;
    else if (posMv <= negMv - hyst / 2)
      rawResult = 1'b0;
  end
endmodule

// >>> test_analog_comparator_control.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end

module test_analog_comparator_control;
  localparam logic [8:0] A_CA = 9'h038;
  localparam logic [8:0] A_CB = 9'h034;
  localparam logic [8:0] A_DI = 9'h180;
  localparam logic [8:0] A_ST = 9'h040;
  localparam logic [8:0] A_MK = 9'h044;
  logic                                sys_clk;
  logic                                nrst;
  logic                                rawResult;
  logic                                converterEnable;
  logic                                positivePinIn;
  logic                                negativePinIn;
  logic                                globalIrqEnable;
  logic                                vectorAck;
  logic                                resultPinOut;
  logic                                resultPinOeN;
  logic                                captureIn;
  logic                                portInPositive;
  logic                                portInNegative;
  logic                                comparatorIrq;
  logic                                irq;
  logic                                waitrequest;
  logic [31:0]                         readdata;
  logic [7:0]                          rd;
  analog_comparator_pkg::av_req_t      avReq;
  analog_comparator_pkg::analog_ctrl_t anaCtrl;
  int                                  posPinMv;
  int                                  negPinMv;
  int                                  muxMv;
  int                                  failures;
  int                                  numChecks;

  analog_comparator_control i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .avReq(avReq), .readdata(readdata), .waitrequest(waitrequest),
    .rawResult(rawResult), .anaCtrl(anaCtrl), .converterEnable(converterEnable),
    .positivePinIn(positivePinIn), .negativePinIn(negativePinIn), .portInPositive(portInPositive),
    .portInNegative(portInNegative), .resultPinOut(resultPinOut), .resultPinOeN(resultPinOeN),
    .captureIn(captureIn), .globalIrqEnable(globalIrqEnable), .vectorAck(vectorAck),
    .comparatorIrq(comparatorIrq), .irq(irq)
  );

  comparator_core_model i_core (
    .anaCtrl(anaCtrl), .posPinMv(posPinMv), .negPinMv(negPinMv), .muxMv(muxMv), .rawResult(rawResult)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic stop_test;
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic waitClk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [8:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avReq <= '{read: !wr, write: wr, address: a, writedata: {24'h000000, d}, byteenable: 4'hF};
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (waitrequest !== 1'b0);
    rd = readdata[7:0];
    avReq.read <= 1'b0;
    avReq.write <= 1'b0;
    `CHK("waitCycles", 2, n)
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    waitClk(2);
  endtask

  task automatic rdChk(input string n, input logic [8:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(n, e, rd)
  endtask

  // drive the positive pin above or below the negative pin
  task automatic setCmp(input logic hi);
    @(posedge sys_clk);
    posPinMv <= hi ? 600 : 400;
    waitClk(5);
  endtask

  task automatic testReset;
    rdChk("ctrlA", A_CA, 8'h00);
    rdChk("ctrlB", A_CB, 8'h00);
    rdChk("didr", A_DI, 8'h00);
    rdChk("status", A_ST, 8'h00);
    rdChk("mask", A_MK, 8'h00);
    rdChk("unmapped", 9'h1FC, 8'h00);
    `CHK("oeN", 1'b1, resultPinOeN)
  endtask

  task automatic testCtrlB;
    wr(A_CB, 8'hFF);
    rdChk("ctrlB", A_CB, 8'hD4);
    `CHK("hystEn", 1'b1, anaCtrl.hystEnable)
    `CHK("hystLvl", 1'b1, anaCtrl.hystLevel)
    `CHK("negMux", 1'b1, anaCtrl.negMuxSelect)
    @(posedge sys_clk);
    converterEnable <= 1'b1;
    waitClk(3);
    `CHK("negMuxConv", 1'b0, anaCtrl.negMuxSelect)
    converterEnable <= 1'b0;
    wr(A_CB, 8'h40);
    `CHK("hystOff", 1'b0, anaCtrl.hystEnable)
    `CHK("hystLvlOff", 1'b0, anaCtrl.hystLevel)
    setCmp(1'b1);
    `CHK("pinOff", 1'b0, resultPinOut)
    `CHK("oeOff", 1'b1, resultPinOeN)
    wr(A_CB, 8'h10);
    `CHK("pinOn", 1'b1, resultPinOut)
    `CHK("oeOn", 1'b0, resultPinOeN)
    setCmp(1'b0);
    `CHK("pinLow", 1'b0, resultPinOut)
    wr(A_CB, 8'h00);
  endtask

  // interrupt enable stays clear while power and input change
  task automatic testCtrlA;
    wr(A_CA, 8'hC0);
    `CHK("powerOff", 1'b1, anaCtrl.powerOff)
    `CHK("bandgap", 1'b1, anaCtrl.posSelBandgap)
    wr(A_CA, 8'h40);
    waitClk(3);
    bus(1'b0, A_CA, 8'h00);
    `CHK("resultBg", 1'b1, rd[5])
    wr(A_CA, 8'h00);
    waitClk(3);
    wr(A_CA, 8'h10);
    rdChk("ctrlAClr", A_CA, 8'h00);
  endtask

  // mode changed only while interrupt enable is clear
  task automatic testModes;
    wr(A_MK, 8'h01);
    for (int m = 0; m < 4; m++)
    begin
      wr(A_CA, 8'h10 | 8'(m));
      setCmp(1'b1);
      bus(1'b0, A_CA, 8'h00);
      `CHK("flagRise", logic'(m == 0 || m == 3), rd[4])
      wr(A_CA, 8'h10 | 8'(m));
      setCmp(1'b0);
      bus(1'b0, A_CA, 8'h00);
      `CHK("flagFall", logic'(m == 0 || m == 2), rd[4])
      rdChk("status", A_ST, {6'h00, 1'b1, logic'(m != 1)});
      `CHK("irqMasked", logic'(m != 1), irq)
      wr(A_ST, 8'h03);
      `CHK("irqClr", 1'b0, irq)
    end
    wr(A_MK, 8'h00);
  endtask

  task automatic testIrq;
    wr(A_CA, 8'h1B);
    @(posedge sys_clk);
    globalIrqEnable <= 1'b1;
    setCmp(1'b1);
    `CHK("cmpIrq", 1'b1, comparatorIrq)
    globalIrqEnable <= 1'b0;
    waitClk(2);
    `CHK("cmpIrqGie", 1'b0, comparatorIrq)
    globalIrqEnable <= 1'b1;
    wr(A_CA, 8'h0B);
    `CHK("cmpIrqW0", 1'b1, comparatorIrq)
    @(posedge sys_clk);
    vectorAck <= 1'b1;
    @(posedge sys_clk);
    vectorAck <= 1'b0;
    waitClk(3);
    `CHK("cmpIrqAck", 1'b0, comparatorIrq)
    rdChk("ctrlAAck", A_CA, 8'h2B);
    wr(A_CA, 8'h13);
    setCmp(1'b0);
    rdChk("ctrlAOff", A_CA, 8'h03);
    globalIrqEnable <= 1'b0;
  endtask

  task automatic testCapture;
    wr(A_CA, 8'h04);
    rdChk("ctrlACap", A_CA, 8'h04);
    setCmp(1'b1);
    `CHK("capOn", 1'b1, captureIn)
    wr(A_CA, 8'h10);
    `CHK("capOff", 1'b0, captureIn)
    setCmp(1'b0);
  endtask

  task automatic testPins;
    @(posedge sys_clk);
    positivePinIn <= 1'b1;
    negativePinIn <= 1'b1;
    waitClk(5);
    `CHK("portPos", 1'b1, portInPositive)
    `CHK("portNeg", 1'b1, portInNegative)
    wr(A_DI, 8'h10);
    `CHK("portNegOff", 1'b0, portInNegative)
    `CHK("portPosOn", 1'b1, portInPositive)
    wr(A_DI, 8'h18);
    `CHK("portPosOff", 1'b0, portInPositive)
    rdChk("didr", A_DI, 8'h18);
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    stop_test;
  end

  initial
  begin
    failures = 0;
    numChecks = 0;
    nrst = 1'b0;
    avReq = '0;
    posPinMv = 400;
    negPinMv = 500;
    muxMv = 0;
    converterEnable = 1'b0;
    positivePinIn = 1'b0;
    negativePinIn = 1'b0;
    globalIrqEnable = 1'b0;
    vectorAck = 1'b0;
    repeat (5) @(posedge sys_clk);
    `CHK("waitReset", 1'b1, waitrequest)
    nrst <= 1'b1;
    testReset;
    testCtrlB;
    testCtrlA;
    testModes;
    testIrq;
    testCapture;
    testPins;
    stop_test;
  end
endmodule
